// >>> string_index_stepper_params.svh
// constants for the string index stepper
// assumes a 16-bit offset space and a single core clock
`ifndef STRING_INDEX_STEPPER_PARAMS_SVH
`define STRING_INDEX_STEPPER_PARAMS_SVH
`define SIS_IDX_W 16
`define SIS_DATA_W 16
`define SIS_IDX_RESET 16'h0000
`define SIS_CNT_RESET 16'h0000
`define SIS_STEP_BYTE 16'h0001
`define SIS_STEP_WORD 16'h0002
`define SIS_BYTE_MASK 16'h00FF
`endif

// >>> string_index_pkg.sv
// types shared by the string index stepper and its testbench
// assumes nothing beyond the params header
package string_index_pkg;
  typedef enum logic [2:0] {
    OP_LOAD,
    OP_STORE,
    OP_MOVE,
    OP_COMPARE,
    OP_SCAN,
    OP_PORT_IN,
    OP_PORT_OUT
  } string_op_t;
  typedef enum logic [1:0] {
    PFX_NONE,
    PFX_ITERATE,
    PFX_WHILE_EQUAL,
    PFX_WHILE_UNEQUAL
  } prefix_t;
endpackage : string_index_pkg

// >>> index_step_if.sv
// carrier between the stepper and its step arithmetic
// assumes both ends on the core clock
`timescale 1ns/1ps
interface index_step_if;
  logic word_size;
  logic direction_flag;
  logic [15:0] source_index;
  logic [15:0] destination_index;
  logic [15:0] next_source_index;
  logic [15:0] next_destination_index;
  modport ctrl (output word_size, output direction_flag, output source_index,
    output destination_index, input next_source_index, input next_destination_index);
  modport unit (input word_size, input direction_flag, input source_index,
    input destination_index, output next_source_index, output next_destination_index);
endinterface : index_step_if

// >>> index_step_unit.sv
// next-offset arithmetic for both index registers
// assumes wrap-around at the 16-bit offset boundary
`timescale 1ns/1ps
`include "string_index_stepper_params.svh"
module index_step_unit (
  index_step_if.unit step
);
  logic [15:0] mag;
  assign mag = step.word_size ? `SIS_STEP_WORD : `SIS_STEP_BYTE;
  // forward walks up, backward walks down
  assign step.next_source_index = step.direction_flag ?
    step.source_index - mag : step.source_index + mag;
  assign step.next_destination_index = step.direction_flag ?
    step.destination_index - mag : step.destination_index + mag;
endmodule : index_step_unit

// >>> string_index_stepper.sv
// string-instruction offset sequencer with automatic index stepping
// assumes memory answers on the same clock with a one-cycle ack pulse
`timescale 1ns/1ps
`include "string_index_stepper_params.svh"
// Behaviour
// - single-string ops use one index register
// - two-string ops: source first, destination second
// - indices step automatically after each component
// - step size follows component size
// - flag 0 increments, flag 1 decrements
// - one component per run; prefix repeats
module string_index_stepper (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // index register loading, taken only while idle
  input wire logic idx_load_in,
  input wire logic [15:0] source_index_in,
  input wire logic [15:0] destination_index_in,
  // instruction start
  input wire logic start_in,
  input wire string_index_pkg::string_op_t op_in,
  input wire string_index_pkg::prefix_t prefix_in,
  input wire logic word_size_in,
  input wire logic direction_flag_in,
  input wire logic [15:0] count_in,
  input wire logic [15:0] acc_in,
  input wire logic [15:0] port_data_in,
  // memory
  output logic mem_req_out,
  output logic mem_we_out,
  output logic mem_use_dst_out,
  output logic mem_word_out,
  output logic [15:0] mem_addr_out,
  output logic [15:0] mem_wdata_out,
  input wire logic mem_ack_in,
  input wire logic [15:0] mem_rdata_in,
  // status
  output logic busy_out,
  output logic done_out,
  output logic port_write_out,
  output logic equal_out,
  output logic [15:0] data_out,
  output logic [15:0] count_out,
  output logic [15:0] source_index_out,
  output logic [15:0] destination_index_out
);
  typedef enum logic [2:0] {ST_IDLE, ST_SRC, ST_DST, ST_STEP} state_t;
  state_t state_q;
  string_index_pkg::string_op_t op_q;
  string_index_pkg::prefix_t prefix_q;
  logic word_q;
  logic dir_q;
  logic [15:0] src_q;
  logic [15:0] dst_q;
  logic [15:0] cnt_q;
  logic [15:0] data_q;
  logic [15:0] acc_q;
  logic [15:0] port_q;
  logic equal_q;
  logic done_q;
  logic port_wr_q;
  logic uses_src;
  logic uses_dst;
  logic dst_writes;
  logic compares;
  logic [15:0] mask;
  logic [15:0] cmp_a;
  logic [15:0] cmp_b;
  logic cmp_eq;
  logic last;
  index_step_if step ();
  index_step_unit u_step (
    .step(step.unit)
  );
  assign step.word_size = word_q;
  assign step.direction_flag = dir_q;
  assign step.source_index = src_q;
  assign step.destination_index = dst_q;
  // which index each operation consumes
  always_comb begin
    uses_src = 1'b0;
    uses_dst = 1'b0;
    dst_writes = 1'b0;
    compares = 1'b0;
    unique case (op_q)
      string_index_pkg::OP_LOAD: uses_src = 1'b1;
      string_index_pkg::OP_PORT_OUT: uses_src = 1'b1;
      string_index_pkg::OP_STORE: begin
        uses_dst = 1'b1;
        dst_writes = 1'b1;
      end
      string_index_pkg::OP_PORT_IN: begin
        uses_dst = 1'b1;
        dst_writes = 1'b1;
      end
      string_index_pkg::OP_SCAN: begin
        uses_dst = 1'b1;
        compares = 1'b1;
      end
      string_index_pkg::OP_MOVE: begin
        uses_src = 1'b1;
        uses_dst = 1'b1;
        dst_writes = 1'b1;
      end
      string_index_pkg::OP_COMPARE: begin
        uses_src = 1'b1;
        uses_dst = 1'b1;
        compares = 1'b1;
      end
      default: begin
        uses_src = 1'b0;
        uses_dst = 1'b0;
      end
    endcase
  end
  assign mask = word_q ? 16'hFFFF : `SIS_BYTE_MASK;
  // compare source (or accumulator) against the destination read
  assign cmp_a = (op_q == string_index_pkg::OP_SCAN) ? (acc_q & mask) : (data_q & mask);
  assign cmp_b = mem_rdata_in & mask;
  assign cmp_eq = (cmp_a == cmp_b);
  // memory request follows the state
  always_comb begin
    mem_req_out = (state_q == ST_SRC) || (state_q == ST_DST);
    mem_use_dst_out = (state_q == ST_DST);
    mem_we_out = (state_q == ST_DST) && dst_writes;
    mem_addr_out = (state_q == ST_DST) ? dst_q : src_q;
    mem_word_out = word_q;
    if (op_q == string_index_pkg::OP_PORT_IN) begin
      mem_wdata_out = port_q & mask;
    end else if (op_q == string_index_pkg::OP_STORE) begin
      mem_wdata_out = acc_q & mask;
    end else begin
      mem_wdata_out = data_q & mask;
    end
  end
  // iteration ends on count, or on the compare outcome for conditional prefixes
  always_comb begin
    last = (prefix_q == string_index_pkg::PFX_NONE) || (cnt_q == 16'h0001);
    if (compares && (prefix_q == string_index_pkg::PFX_WHILE_EQUAL) && !equal_q) begin
      last = 1'b1;
    end
    if (compares && (prefix_q == string_index_pkg::PFX_WHILE_UNEQUAL) && equal_q) begin
      last = 1'b1;
    end
  end
  // sequencer
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // a zero count under a prefix runs no component
          if (start_in && !(prefix_in != string_index_pkg::PFX_NONE && count_in == 16'h0000))
          begin
            state_q <= (op_in == string_index_pkg::OP_LOAD || op_in == string_index_pkg::OP_MOVE
              || op_in == string_index_pkg::OP_COMPARE || op_in == string_index_pkg::OP_PORT_OUT)
              ? ST_SRC : ST_DST;
          end
        end
        ST_SRC: if (mem_ack_in) state_q <= uses_dst ? ST_DST : ST_STEP;
        ST_DST: if (mem_ack_in) state_q <= ST_STEP;
        ST_STEP: begin
          if (last) begin
            state_q <= ST_IDLE;
          end else begin
            state_q <= uses_src ? ST_SRC : ST_DST;
          end
        end
      endcase
    end
  end
  // instruction context latched at start
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      op_q <= string_index_pkg::OP_LOAD;
      prefix_q <= string_index_pkg::PFX_NONE;
      word_q <= 1'b0;
      dir_q <= 1'b0;
      acc_q <= 16'h0000;
      port_q <= 16'h0000;
    end else if (state_q == ST_IDLE && start_in) begin
      op_q <= op_in;
      prefix_q <= prefix_in;
      word_q <= word_size_in;
      dir_q <= direction_flag_in;
      acc_q <= acc_in;
      port_q <= port_data_in;
    end
  end
  // index registers: loaded while idle, stepped after every component
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      src_q <= `SIS_IDX_RESET;
      dst_q <= `SIS_IDX_RESET;
    end else if (state_q == ST_IDLE && idx_load_in) begin
      src_q <= source_index_in;
      dst_q <= destination_index_in;
    end else if (state_q == ST_STEP) begin
      if (uses_src) src_q <= step.next_source_index;
      if (uses_dst) dst_q <= step.next_destination_index;
    end
  end
  // repeat counter, decremented once per component under a prefix
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt_q <= `SIS_CNT_RESET;
    end else if (state_q == ST_IDLE && start_in) begin
      cnt_q <= count_in;
    end else if (state_q == ST_STEP && prefix_q != string_index_pkg::PFX_NONE) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end
  // data path and compare result
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      data_q <= 16'h0000;
      equal_q <= 1'b0;
    end else begin
      if (state_q == ST_SRC && mem_ack_in) data_q <= mem_rdata_in & mask;
      if (state_q == ST_DST && mem_ack_in && compares) equal_q <= cmp_eq;
    end
  end
  // completion and port strobes, one cycle each
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      done_q <= 1'b0;
      port_wr_q <= 1'b0;
    end else begin
      done_q <= (state_q == ST_STEP) && last;
      port_wr_q <= (state_q == ST_STEP) && (op_q == string_index_pkg::OP_PORT_OUT);
    end
  end
  assign busy_out = (state_q != ST_IDLE);
  assign done_out = done_q;
  assign port_write_out = port_wr_q;
  assign equal_out = equal_q;
  assign data_out = data_q;
  assign count_out = cnt_q;
  assign source_index_out = src_q;
  assign destination_index_out = dst_q;
endmodule : string_index_stepper

// >>> string_index_stepper_checker.sv
// port assertions for the string index stepper
// assumes direction_flag_in is held steady through an instruction
`timescale 1ns/1ps
module string_index_stepper_checker (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // watched ports
  input wire logic idx_load_in,
  input wire logic direction_flag_in,
  input wire logic mem_ack_in,
  input wire logic mem_req_out,
  input wire logic mem_use_dst_out,
  input wire logic mem_word_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [15:0] source_index_out,
  input wire logic [15:0] destination_index_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic [15:0] step;
  assign step = direction_flag_in ? (mem_word_out ? 16'hFFFE : 16'hFFFF)
    : (mem_word_out ? 16'h0002 : 16'h0001);
  sequence waiting_s; mem_req_out && !mem_ack_in; endsequence
  sequence stepped_s; $past(busy_out) && !$past(rst_in); endsequence
  src_addr_a: assert property (
    mem_req_out && !mem_use_dst_out |-> mem_addr_out == source_index_out) else $error("src addr");
  dst_addr_a: assert property (
    mem_req_out && mem_use_dst_out |-> mem_addr_out == destination_index_out)
    else $error("dst addr");
  req_hold_a: assert property (
    waiting_s |=> mem_req_out && $stable(mem_addr_out)) else $error("request dropped");
  src_step_a: assert property (
    stepped_s ##0 $changed(source_index_out) |->
    source_index_out == $past(source_index_out) + $past(step)) else $error("src step");
  dst_step_a: assert property (
    stepped_s ##0 $changed(destination_index_out) |->
    destination_index_out == $past(destination_index_out) + $past(step)) else $error("dst step");
  idle_quiet_a: assert property (
    !busy_out |-> !mem_req_out) else $error("request while idle");
  done_end_a: assert property (
    done_out |-> $past(busy_out) && !busy_out ##1 !done_out) else $error("done pulse");
  idle_hold_a: assert property (
    !busy_out && !idx_load_in |=> $stable(source_index_out) && $stable(destination_index_out))
    else $error("index moved while idle");
endmodule : string_index_stepper_checker
bind string_index_stepper string_index_stepper_checker chk_i (.clk_sys_in, .rst_in, .idx_load_in,
  .direction_flag_in, .mem_ack_in, .mem_req_out, .mem_use_dst_out, .mem_word_out, .mem_addr_out,
  .busy_out, .done_out, .source_index_out, .destination_index_out);

// >>> string_memory_model.sv
// memory partner of the stepper, answering after 0 to 3 extra cycles
// assumes one clock shared with the stepper
`timescale 1ns/1ps
module string_memory_model (
  // clock
  input wire logic clk_in,
  // access
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic [1:0] delay_in,
  output logic ack_out = 1'b0,
  output logic [15:0] rdata_out = 16'h0000
);
  logic [15:0] mem [int];
  int wait_n = 0;
  function automatic logic [15:0] peek(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : ~a;
  endfunction : peek
  always @(posedge clk_in) begin
    ack_out <= 1'b0;
    // stale data toggles so a late sample cannot pass by luck
    rdata_out <= ~rdata_out;
    if (req_in && !ack_out) begin
      if (wait_n < delay_in) wait_n <= wait_n + 1;
      else begin
        wait_n <= 0;
        ack_out <= 1'b1;
        if (we_in) mem[addr_in] = wdata_in;
        else rdata_out <= peek(addr_in);
      end
    end
  end
endmodule : string_memory_model

// >>> string_index_stepper_tb_top.sv
// self-checking bench for the string index stepper
// assumes the memory model and checker are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module string_index_stepper_tb_top;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic idx_load_in = 1'b0;
  logic start_in = 1'b0;
  logic word_size_in = 1'b0;
  logic direction_flag_in = 1'b0;
  string_index_pkg::string_op_t op_in = string_index_pkg::OP_LOAD;
  string_index_pkg::prefix_t prefix_in = string_index_pkg::PFX_NONE;
  logic [15:0] count_in = 16'h0000, acc_in = 16'h0000, port_data_in = 16'h0000;
  logic [15:0] source_index_in = 16'h0000, destination_index_in = 16'h0000;
  logic [1:0] delay = 2'h0;
  logic mem_ack_in, mem_req_out, mem_we_out, mem_use_dst_out, mem_word_out;
  logic busy_out, done_out, equal_out, port_write_out;
  logic [15:0] mem_rdata_in, mem_addr_out, mem_wdata_out, data_out, count_out;
  logic [15:0] source_index_out, destination_index_out;
  int errors = 0;
  int samples_checked = 0;
  string_index_stepper uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .idx_load_in(idx_load_in), .source_index_in(source_index_in),
    .destination_index_in(destination_index_in), .start_in(start_in), .op_in(op_in),
    .prefix_in(prefix_in), .word_size_in(word_size_in), .direction_flag_in(direction_flag_in),
    .count_in(count_in), .acc_in(acc_in), .port_data_in(port_data_in),
    .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_use_dst_out(mem_use_dst_out),
    .mem_word_out(mem_word_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in), .busy_out(busy_out),
    .done_out(done_out), .port_write_out(port_write_out), .equal_out(equal_out),
    .data_out(data_out), .count_out(count_out), .source_index_out(source_index_out),
    .destination_index_out(destination_index_out));
  string_memory_model mem_i (.clk_in(clk_sys_in), .req_in(mem_req_out), .we_in(mem_we_out),
    .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .delay_in(delay), .ack_out(mem_ack_in),
    .rdata_out(mem_rdata_in));
  initial begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  task automatic stop_test;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic run(input int op, pf, w, dir, n, input logic [15:0] s);
    logic [15:0] d, m, sv, dv, wv, st, a, p;
    int it, k, pw;
    logic eq;
    d = s ^ 16'h8000;
    m = w ? 16'hFFFF : 16'h00FF;
    st = dir ? (w ? 16'hFFFE : 16'hFFFF) : (w ? 16'h0002 : 16'h0001);
    a = 16'($urandom);
    p = 16'($urandom);
    @(posedge clk_sys_in);
    {idx_load_in, start_in, source_index_in, destination_index_in} <= {2'b11, s, d};
    op_in <= string_index_pkg::string_op_t'(op);
    prefix_in <= string_index_pkg::prefix_t'(pf);
    {word_size_in, direction_flag_in, count_in} <= {1'(w), 1'(dir), 16'(n)};
    {acc_in, port_data_in, delay} <= {a, p, 2'($urandom_range(0, 3))};
    @(posedge clk_sys_in);
    // load and start again while busy: both must be ignored
    source_index_in <= ~s;
    @(posedge clk_sys_in);
    {idx_load_in, start_in} <= 2'b00;
    it = 0;
    do begin
      sv = mem_i.peek(s) & m;
      dv = mem_i.peek(d) & m;
      eq = (op == 4) ? ((a & m) == dv) : (sv == dv);
      wv = op == 1 ? a & m : op == 5 ? p & m : sv;
      if (op inside {0, 2, 3, 6}) s += st;
      if (op != 0 && op != 6) d += st;
      it++;
    end while (pf != 0 && it < n && !(op inside {3, 4} && (pf == 2 && !eq || pf == 3 && eq)));
    k = 0;
    pw = 0;
    do begin
      @(posedge clk_sys_in);
      #1 k++;
      // port strobes stand one cycle each, so polling every cycle sees each one
      if (port_write_out === 1'b1) pw++;
    end while (done_out !== 1'b1 && k < 200);
    `CHK(done_out, 1'b1)
    `CHK(source_index_out, s)
    `CHK(destination_index_out, d)
    if (pf != 0) `CHK(count_out, 16'(n - it))
    else `CHK(count_out, 16'(n))
    if (op inside {3, 4}) `CHK(equal_out, eq)
    if (op inside {0, 6}) `CHK(data_out, sv)
    `CHK(pw, (op == 6) ? it : 0)
    if (op inside {1, 2, 5}) `CHK(mem_i.peek(d - st), wv)
  endtask : run
  initial begin
    void'($urandom(7318));
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (int op = 0; op < 7; op++) begin
      for (int pf = 0; pf < 4; pf++) begin
        run(op, pf, $urandom_range(0, 1), $urandom_range(0, 1), $urandom_range(1, 4),
          16'($urandom));
      end
    end
    // index wrap at the top and at the bottom of the offset space
    run(2, 1, 1, 0, 3, 16'hFFFF);
    run(3, 2, 0, 1, 4, 16'h0000);
    // reset again while idle: indices and count return to zero, then work resumes
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1 `CHK(source_index_out, 16'h0000)
    `CHK(destination_index_out, 16'h0000)
    `CHK(count_out, 16'h0000)
    `CHK(busy_out, 1'b0)
    @(posedge clk_sys_in);
    rst_in <= 1'b0;
    run(4, 3, 1, 1, 3, 16'h0010);
    stop_test();
  end
  initial begin
    repeat (8000) @(posedge clk_sys_in);
    errors++;
    stop_test();
  end
endmodule : string_index_stepper_tb_top
